// file: hdl/hspc_config_bank.sv
// Hub string storage, charging enables, drive boost and pair swap bank
//
// Notes on behaviour
// - Product string bytes live at 0x54 through 0x91.
// - Serial string bytes live at 0x92 through 0xcf.
// - Each character is UTF-16LE: low byte first, high byte at next address.
// - Each string holds at most 31 characters, 62 bytes.
// - Charging enable bits 1 to 4 govern downstream ports 1 to 4; rest reserved.
// - Upstream boost is bits 1:0, levels none, low, medium, high.
// - Downstream boost byte holds ports 4..1 in 2-bit fields, same levels.
// - Swap bit 0 is upstream, bits 1 to 4 downstream ports 1 to 4.
// - Swap bit 0 keeps D+ on positive pin; 1 moves D+ to negative pin.
`timescale 1ns/1ns
`default_nettype none
module hspc_config_bank (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Configuration byte port
    input wire logic cfg_wr_en_in,
    input wire logic cfg_rd_en_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [7:0] cfg_wr_data_in,
    output logic [7:0] cfg_rd_data_out,
    output logic cfg_rd_valid_out,
    // Core line signals, index 0 upstream, 1..4 downstream
    input wire logic [4:0] core_dplus_in,
    input wire logic [4:0] core_dminus_in,
    // Pins
    output logic upstream_positive_pin_out,
    output logic upstream_negative_pin_out,
    output logic [3:0] downstream_positive_pins_out,
    output logic [3:0] downstream_negative_pins_out,
    // Port controls
    output logic [3:0] port_charging_enable_out,
    output hspc_pkg::hspc_boost_t upstream_boost_level_out,
    output hspc_pkg::hspc_boost_t port1_boost_level_out,
    output hspc_pkg::hspc_boost_t port2_boost_level_out,
    output hspc_pkg::hspc_boost_t port3_boost_level_out,
    output hspc_pkg::hspc_boost_t port4_boost_level_out
);
    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic in_strings(input logic [7:0] a);
        in_strings = (a >= hspc_pkg::PRODUCT_FIRST) && (a <= hspc_pkg::SERIAL_LAST);
    endfunction : in_strings

    // Product first, serial straight after, so one offset covers both
    function automatic logic [hspc_pkg::STORE_AW-1:0] store_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - hspc_pkg::PRODUCT_FIRST;
        store_index = d[hspc_pkg::STORE_AW-1:0];
    endfunction : store_index

    // Strobe for one control byte location
    function automatic logic wr_hit(input logic en, input logic [7:0] a, input logic [7:0] ofs);
        wr_hit = en && (a == ofs);
    endfunction : wr_hit

    // One 2-bit level out of a packed boost byte, field 0 in bits 1:0
    function automatic hspc_pkg::hspc_boost_t boost_field(input logic [7:0] b, input int idx);
        logic [1:0] f;
        f = b[idx * hspc_pkg::BOOST_W +: hspc_pkg::BOOST_W];
        boost_field = hspc_pkg::hspc_boost_t'(f);
    endfunction : boost_field

    hspc_store_if store_bus ();

    // No reset on the store: bytes are unknown until the source writes them
    hspc_string_store u_hspc_string_store (
        .sys_clk_in(sys_clk_in),
        .port(store_bus.store)
    );

    logic [7:0] charging_enable_per_port;
    logic [7:0] upstream_drive_boost;
    logic [7:0] downstream_drive_boost;
    logic [7:0] differential_pair_swap;
    logic rd_pending;
    logic rd_from_store;
    logic [7:0] rd_reg_value;

    // ----------------------------------------
    // String bytes
    // ----------------------------------------
    // Bytes stored exactly as written; UTF-16LE order is kept by address alone
    assign store_bus.wr_en = cfg_wr_en_in && in_strings(cfg_addr_in);
    assign store_bus.wr_addr = store_index(cfg_addr_in);
    assign store_bus.wr_data = cfg_wr_data_in;
    // Parked at zero off the strings, so the store never reads past its end
    assign store_bus.rd_addr = in_strings(cfg_addr_in) ? store_index(cfg_addr_in) : 7'h00;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // Reserved bits are dropped on write so they always read back as zero
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            charging_enable_per_port <= hspc_pkg::CHARGING_ENABLE_RST;
        end else if (wr_hit(cfg_wr_en_in, cfg_addr_in, hspc_pkg::CHARGING_ENABLE_OFS)) begin
            charging_enable_per_port <= cfg_wr_data_in & hspc_pkg::CHARGING_ENABLE_MASK;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            upstream_drive_boost <= hspc_pkg::UPSTREAM_BOOST_RST;
        end else if (wr_hit(cfg_wr_en_in, cfg_addr_in, hspc_pkg::UPSTREAM_BOOST_OFS)) begin
            upstream_drive_boost <= cfg_wr_data_in & hspc_pkg::UPSTREAM_BOOST_MASK;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            downstream_drive_boost <= hspc_pkg::DOWNSTREAM_BOOST_RST;
        end else if (wr_hit(cfg_wr_en_in, cfg_addr_in, hspc_pkg::DOWNSTREAM_BOOST_OFS)) begin
            downstream_drive_boost <= cfg_wr_data_in & hspc_pkg::DOWNSTREAM_BOOST_MASK;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            differential_pair_swap <= hspc_pkg::PAIR_SWAP_RST;
        end else if (wr_hit(cfg_wr_en_in, cfg_addr_in, hspc_pkg::PAIR_SWAP_OFS)) begin
            differential_pair_swap <= cfg_wr_data_in & hspc_pkg::PAIR_SWAP_MASK;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Two cycles so store data and register data leave through the same flop
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rd_pending <= 1'b0;
            rd_from_store <= 1'b0;
            rd_reg_value <= 8'h00;
        end else begin
            rd_pending <= cfg_rd_en_in;
            rd_from_store <= in_strings(cfg_addr_in);
            case (cfg_addr_in)
                hspc_pkg::CHARGING_ENABLE_OFS: rd_reg_value <= charging_enable_per_port;
                hspc_pkg::UPSTREAM_BOOST_OFS: rd_reg_value <= upstream_drive_boost;
                hspc_pkg::DOWNSTREAM_BOOST_OFS: rd_reg_value <= downstream_drive_boost;
                hspc_pkg::PAIR_SWAP_OFS: rd_reg_value <= differential_pair_swap;
                default: rd_reg_value <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cfg_rd_valid_out <= 1'b0;
            cfg_rd_data_out <= 8'h00;
        end else begin
            cfg_rd_valid_out <= rd_pending;
            if (rd_pending) begin
                cfg_rd_data_out <= rd_from_store ? store_bus.rd_data : rd_reg_value;
            end
        end
    end

    // ----------------------------------------
    // Port controls
    // ----------------------------------------
    // Extra flop stage, so port controls lag a register write by one edge
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            port_charging_enable_out <= 4'h0;
            upstream_boost_level_out <= hspc_pkg::HSPC_BOOST_NONE;
            port1_boost_level_out <= hspc_pkg::HSPC_BOOST_NONE;
            port2_boost_level_out <= hspc_pkg::HSPC_BOOST_NONE;
            port3_boost_level_out <= hspc_pkg::HSPC_BOOST_NONE;
            port4_boost_level_out <= hspc_pkg::HSPC_BOOST_NONE;
        end else begin
            port_charging_enable_out <= charging_enable_per_port[4:1];
            upstream_boost_level_out <= boost_field(upstream_drive_boost, 0);
            port1_boost_level_out <= boost_field(downstream_drive_boost, 0);
            port2_boost_level_out <= boost_field(downstream_drive_boost, 1);
            port3_boost_level_out <= boost_field(downstream_drive_boost, 2);
            port4_boost_level_out <= boost_field(downstream_drive_boost, 3);
        end
    end

    // ----------------------------------------
    // Pair swap routing
    // ----------------------------------------
    // Registered, so pins lag the core by one cycle
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            upstream_positive_pin_out <= 1'b0;
            upstream_negative_pin_out <= 1'b0;
        end else if (differential_pair_swap[hspc_pkg::SWAP_UP_BIT]) begin
            upstream_positive_pin_out <= core_dminus_in[0];
            upstream_negative_pin_out <= core_dplus_in[0];
        end else begin
            upstream_positive_pin_out <= core_dplus_in[0];
            upstream_negative_pin_out <= core_dminus_in[0];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            downstream_positive_pins_out <= 4'h0;
            downstream_negative_pins_out <= 4'h0;
        end else begin
            for (int p = 0; p < hspc_pkg::NUM_DOWN_PORTS; p++) begin
                if (differential_pair_swap[p + 1]) begin
                    downstream_positive_pins_out[p] <= core_dminus_in[p + 1];
                    downstream_negative_pins_out[p] <= core_dplus_in[p + 1];
                end else begin
                    downstream_positive_pins_out[p] <= core_dplus_in[p + 1];
                    downstream_negative_pins_out[p] <= core_dminus_in[p + 1];
                end
            end
        end
    end
endmodule : hspc_config_bank
`default_nettype wire

// file: hdl/hspc_pkg.sv
// Package of offsets, field layouts and reset values for the hub config bank
package hspc_pkg;
    // ----------------------------------------
    // Byte locations
    // ----------------------------------------
    localparam logic [7:0] PRODUCT_FIRST = 8'h54;
    localparam logic [7:0] PRODUCT_LAST = 8'h91;
    localparam logic [7:0] SERIAL_FIRST = 8'h92;
    localparam logic [7:0] SERIAL_LAST = 8'hcf;
    localparam logic [7:0] CHARGING_ENABLE_OFS = 8'hd0;
    localparam logic [7:0] UPSTREAM_BOOST_OFS = 8'hf6;
    localparam logic [7:0] DOWNSTREAM_BOOST_OFS = 8'hf8;
    localparam logic [7:0] PAIR_SWAP_OFS = 8'hfa;

    // ----------------------------------------
    // String storage
    // ----------------------------------------
    localparam int STRING_MAX_CHARS = 31;
    localparam int STRING_BYTES = 2 * STRING_MAX_CHARS;
    localparam int STORE_BYTES = 2 * STRING_BYTES;
    localparam int STORE_AW = 7;

    // ----------------------------------------
    // Field layouts
    // ----------------------------------------
    localparam int NUM_DOWN_PORTS = 4;
    localparam logic [7:0] CHARGING_ENABLE_MASK = 8'h1e;
    localparam logic [7:0] UPSTREAM_BOOST_MASK = 8'h03;
    localparam logic [7:0] DOWNSTREAM_BOOST_MASK = 8'hff;
    localparam logic [7:0] PAIR_SWAP_MASK = 8'h1f;
    localparam int BOOST_W = 2;
    localparam int SWAP_UP_BIT = 0;

    // ----------------------------------------
    // Boost levels and reset values
    // ----------------------------------------
    typedef enum logic [1:0] {
        HSPC_BOOST_NONE = 2'h0,
        HSPC_BOOST_LOW = 2'h1,
        HSPC_BOOST_MEDIUM = 2'h2,
        HSPC_BOOST_HIGH = 2'h3
    } hspc_boost_t;

    localparam logic [7:0] CHARGING_ENABLE_RST = 8'h00;
    localparam logic [7:0] UPSTREAM_BOOST_RST = 8'h00;
    localparam logic [7:0] DOWNSTREAM_BOOST_RST = 8'h00;
    localparam logic [7:0] PAIR_SWAP_RST = 8'h00;
endpackage : hspc_pkg

// file: hdl/hspc_store_if.sv
// Interface between the config bank and its string byte store
`timescale 1ns/1ns
`default_nettype none
interface hspc_store_if;
    logic wr_en;
    logic [hspc_pkg::STORE_AW-1:0] wr_addr;
    logic [7:0] wr_data;
    logic [hspc_pkg::STORE_AW-1:0] rd_addr;
    logic [7:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
        input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
        output rd_data);
endinterface : hspc_store_if
`default_nettype wire

// file: hdl/hspc_string_store.sv
// Byte store holding the product and serial descriptor strings
`timescale 1ns/1ns
`default_nettype none
module hspc_string_store (
    // Clock
    input wire logic sys_clk_in,
    // Access
    hspc_store_if.store port
);
    logic [7:0] mem [hspc_pkg::STORE_BYTES];

    // ----------------------------------------
    // Write and registered read
    // ----------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (port.wr_en) begin
            mem[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        port.rd_data <= mem[port.rd_addr];
    end
endmodule : hspc_string_store
`default_nettype wire

// file: dv/hspc_cfg_source.sv
// Configuration source model issuing byte writes and reads
`timescale 1ns/1ns
`default_nettype none
module hspc_cfg_source (
    // Clock
    input wire logic sys_clk_in,
    // Byte port
    output logic wr_en_out,
    output logic rd_en_out,
    output logic [7:0] addr_out,
    output logic [7:0] wr_data_out,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_valid_in
);
    initial begin
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
        addr_out = 8'h00;
        wr_data_out = 8'h00;
    end
    task write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        #1;
        wr_en_out = 1'b1;
        addr_out = a;
        wr_data_out = d;
        @(posedge sys_clk_in);
        #1;
        wr_en_out = 1'b0;
        // Idle lines show the inverse so a stale value never passes
        addr_out = ~a;
        wr_data_out = ~d;
    endtask : write_byte
    task read_byte(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge sys_clk_in);
        #1;
        rd_en_out = 1'b1;
        addr_out = a;
        @(posedge sys_clk_in);
        #1;
        rd_en_out = 1'b0;
        addr_out = ~a;
        repeat (3) begin
            @(posedge sys_clk_in);
            #1;
            if (rd_valid_in === 1'b1 && !ok) begin
                d = rd_data_in;
                ok = 1'b1;
            end
        end
    endtask : read_byte
    // Low byte first, high byte at the next location, no gaps
    task write_char(input logic [7:0] base, input int idx, input logic [15:0] ch);
        write_byte(base + 8'(2 * idx), ch[7:0]);
        write_byte(base + 8'(2 * idx + 1), ch[15:8]);
    endtask : write_char
endmodule : hspc_cfg_source
`default_nettype wire

// file: dv/hspc_config_bank_asserts.sv
// Checker of read timing, field routing and pin swapping of the config bank
`timescale 1ns/1ns
`default_nettype none
module hspc_config_bank_asserts (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Configuration byte port
    input wire logic cfg_wr_en_in,
    input wire logic cfg_rd_en_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [7:0] cfg_wr_data_in,
    input wire logic [7:0] cfg_rd_data_out,
    input wire logic cfg_rd_valid_out,
    // Core levels and pins
    input wire logic [4:0] core_dplus_in,
    input wire logic [4:0] core_dminus_in,
    input wire logic upstream_positive_pin_out,
    input wire logic upstream_negative_pin_out,
    input wire logic [3:0] downstream_positive_pins_out,
    input wire logic [3:0] downstream_negative_pins_out,
    // Port controls
    input wire logic [3:0] port_charging_enable_out,
    input wire hspc_pkg::hspc_boost_t upstream_boost_level_out,
    input wire hspc_pkg::hspc_boost_t port1_boost_level_out,
    input wire hspc_pkg::hspc_boost_t port2_boost_level_out,
    input wire hspc_pkg::hspc_boost_t port3_boost_level_out,
    input wire hspc_pkg::hspc_boost_t port4_boost_level_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    logic [4:0] sw;
    logic um;
    assign um = cfg_addr_in < 8'h54 || (cfg_addr_in > 8'hd0 && cfg_addr_in != 8'hf6
        && cfg_addr_in != 8'hf8 && cfg_addr_in != 8'hfa);
    // Shadow of the swap byte, so pin checks need no internal probe
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sw <= 5'h00;
        end else if (cfg_wr_en_in && cfg_addr_in == hspc_pkg::PAIR_SWAP_OFS) begin
            sw <= cfg_wr_data_in[4:0];
        end
    end
    sequence s_answer;
        ##2 cfg_rd_valid_out;
    endsequence
    property p_rd_latency;
        cfg_rd_en_in |-> s_answer;
    endproperty
    a_rd_latency: assert property (p_rd_latency) else $error("read answer late");
    property p_rd_cause;
        cfg_rd_valid_out |-> $past(cfg_rd_en_in, 2);
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("answer without read");
    property p_unmapped;
        cfg_rd_en_in && um |-> ##2 cfg_rd_data_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_charging;
        cfg_wr_en_in && cfg_addr_in == 8'hd0
            |-> ##2 port_charging_enable_out == $past(cfg_wr_data_in[4:1], 2);
    endproperty
    a_charging: assert property (p_charging) else $error("charging enable wrong");
    property p_up_boost;
        cfg_wr_en_in && cfg_addr_in == 8'hf6
            |-> ##2 upstream_boost_level_out == $past(cfg_wr_data_in[1:0], 2);
    endproperty
    a_up_boost: assert property (p_up_boost) else $error("upstream boost wrong");
    property p_dn_boost;
        cfg_wr_en_in && cfg_addr_in == 8'hf8 |-> ##2 {port4_boost_level_out,
            port3_boost_level_out, port2_boost_level_out, port1_boost_level_out}
            == $past(cfg_wr_data_in, 2);
    endproperty
    a_dn_boost: assert property (p_dn_boost) else $error("downstream boost wrong");
    property p_pos_pins;
        !$past(rst_in) |-> {downstream_positive_pins_out, upstream_positive_pin_out}
            == (($past(sw) & $past(core_dminus_in)) | (~$past(sw) & $past(core_dplus_in)));
    endproperty
    a_pos_pins: assert property (p_pos_pins) else $error("positive pins wrong");
    property p_neg_pins;
        !$past(rst_in) |-> {downstream_negative_pins_out, upstream_negative_pin_out}
            == (($past(sw) & $past(core_dplus_in)) | (~$past(sw) & $past(core_dminus_in)));
    endproperty
    a_neg_pins: assert property (p_neg_pins) else $error("negative pins wrong");
endmodule : hspc_config_bank_asserts
bind hspc_config_bank hspc_config_bank_asserts u_hspc_config_bank_asserts (.*);
`default_nettype wire

// file: dv/hspc_config_bank_tb.sv
// Self-checking bench for the hub config bank
`timescale 1ns/1ns
`default_nettype none
module hspc_config_bank_tb;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wr_en, rd_en, rd_valid, up_p, up_n;
    logic [7:0] addr, wr_data, rd_data, got, e;
    logic [4:0] dp = 5'h15;
    logic [4:0] dm = 5'h0a;
    logic [3:0] dn_p, dn_n, chg;
    logic [1:0] lv;
    hspc_pkg::hspc_boost_t b0, b1, b2, b3, b4;
    logic [7:0] ofs [4] = '{8'hd0, 8'hf6, 8'hf8, 8'hfa};
    logic [7:0] msk [4] = '{8'h1e, 8'h03, 8'hff, 8'h1f};
    int failures = 0;
    int total_checks = 0;
    hspc_config_bank u_hspc_config_bank (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .cfg_wr_en_in(wr_en), .cfg_rd_en_in(rd_en), .cfg_addr_in(addr),
        .cfg_wr_data_in(wr_data), .cfg_rd_data_out(rd_data), .cfg_rd_valid_out(rd_valid),
        .core_dplus_in(dp), .core_dminus_in(dm), .upstream_positive_pin_out(up_p),
        .upstream_negative_pin_out(up_n), .downstream_positive_pins_out(dn_p),
        .downstream_negative_pins_out(dn_n), .port_charging_enable_out(chg),
        .upstream_boost_level_out(b0), .port1_boost_level_out(b1),
        .port2_boost_level_out(b2), .port3_boost_level_out(b3), .port4_boost_level_out(b4));
    hspc_cfg_source u_hspc_cfg_source (.sys_clk_in(sys_clk_in), .wr_en_out(wr_en),
        .rd_en_out(rd_en), .addr_out(addr), .wr_data_out(wr_data), .rd_data_in(rd_data),
        .rd_valid_in(rd_valid));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    task wr(input logic [7:0] a, input logic [7:0] d);
        u_hspc_cfg_source.write_byte(a, d);
    endtask : wr
    task rd_chk(input logic [7:0] a, input logic [7:0] x);
        logic ok;
        u_hspc_cfg_source.read_byte(a, got, ok);
        check({7'h00, ok}, 8'h01);
        check(got, x);
    endtask : rd_chk
    task step();
        @(posedge sys_clk_in);
        #1;
    endtask : step
    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    // Whole run is about 970 cycles
    initial begin
        #50000;
        failures++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge sys_clk_in);
        #1;
        rst_in = 1'b0;
        for (int k = 0; k < 4; k++) begin
            rd_chk(ofs[k], 8'h00);
            wr(ofs[k], 8'hff);
            rd_chk(ofs[k], msk[k]);
        end
        check({4'h0, chg}, 8'h0f);
        check({3'h0, dn_p, up_p}, {3'h0, dm});
        check({3'h0, dn_n, up_n}, {3'h0, dp});
        wr(8'hfa, 8'h0a);
        wr(8'hd0, 8'h0a);
        step();
        check({3'h0, dn_p, up_p}, 8'h1f);
        check({3'h0, dn_n, up_n}, 8'h00);
        check({4'h0, chg}, 8'h05);
        // Lines not complementary, so a pin fed the inverse of its partner shows
        dp = 5'h03;
        dm = 5'h05;
        step();
        check({3'h0, dn_p, up_p}, 8'h01);
        check({3'h0, dn_n, up_n}, 8'h07);
        for (int k = 0; k < 4; k++) begin
            lv = k[1:0];
            wr(8'hf6, {6'h3f, lv});
            wr(8'hf8, {lv, lv + 2'h1, lv + 2'h2, lv + 2'h3});
            step();
            check({6'h00, b0}, {6'h00, lv});
            check({b4, b3, b2, b1}, {lv, lv + 2'h1, lv + 2'h2, lv + 2'h3});
        end
        wr(8'hf6, 8'h00);
        wr(8'hf8, 8'h00);
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 31; i++) begin
                u_hspc_cfg_source.write_char(s[0] ? 8'h92 : 8'h54, i,
                    {8'h30 + 8'(s), 8'h40 + 8'(i)});
            end
        end
        wr(8'h53, 8'hff);
        wr(8'hd1, 8'hff);
        rd_chk(8'h53, 8'h00);
        rd_chk(8'hd1, 8'h00);
        for (int j = 0; j < 124; j++) begin
            e = ((j % 62) % 2 == 1) ? 8'h30 + 8'(j / 62) : 8'h40 + 8'((j % 62) / 2);
            rd_chk(8'h54 + 8'(j), e);
        end
        summarize();
    end
endmodule : hspc_config_bank_tb
`default_nettype wire
